/* logic/aopm_pkg.sv */
// shared constants for the converter output port pin mux
package aopm_pkg;

  // interface selector codes
  localparam logic [1:0] SEL_PAR18 = 2'h0;
  localparam logic [1:0] SEL_PAR16 = 2'h1;
  localparam logic [1:0] SEL_BYTE = 2'h2;
  localparam logic [1:0] SEL_SERIAL = 2'h3;

  // result word width and pin field positions
  localparam int RESULT_W = 18;
  localparam int BIT_CODING = 0;
  localparam int BIT_FORM_LO = 1;
  localparam int BIT_FORM_HI = 2;
  localparam int BIT_DBIT3 = 3;
  localparam int BIT_DBIT4 = 4;
  localparam int BIT_DBIT5 = 5;

  // reset values
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [1:0] RST_FORM = 2'h0;
  localparam logic RST_CODING_STRAIGHT = 1'b1;

  typedef enum {
    AOPM_PAR18,
    AOPM_PAR16,
    AOPM_BYTE,
    AOPM_SERIAL
  } aopm_mode_t;

endpackage

/* logic/aopm_pin_mux.sv */
// output port mode decode and low data pin assignment
`timescale 1ns/1ps

module aopm_pin_mux #(
  parameter int RESULT_W = aopm_pkg::RESULT_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // interface selector pins
  input wire logic ifaceSelLo,
  input wire logic ifaceSelHi,
  // core side: result word in, decoded controls out
  input wire logic [RESULT_W-1:0] resultRaw,
  output logic [RESULT_W-1:0] resultCoded,
  output logic [1:0] portMode,
  output logic serialMode,
  output logic [1:0] formSel,
  // pin 0: data bit 0 or coding select
  input wire logic dbit0OrCodingSelIn,
  output logic dbit0OrCodingSelOut,
  output logic dbit0OrCodingSelOe,
  // pin 1: data bit 1 or form select low
  input wire logic dbit1OrFormSelLoIn,
  output logic dbit1OrFormSelLoOut,
  output logic dbit1OrFormSelLoOe,
  // pin 2: data bit 2 or form select high
  input wire logic dbit2OrFormSelHiIn,
  output logic dbit2OrFormSelHiOut,
  output logic dbit2OrFormSelHiOe,
  // pin 3: always output
  output logic dbit3Out,
  // pins 4 and 5
  output logic [1:0] dbit45Out,
  output logic [1:0] dbit45Oe
);

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rstMeta_ff;
  logic rstSync_ff;
  logic rstN;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end
  assign rstN = rstSync_ff;

  // ------------------------------------------------------------
  // pin input synchronisers
  // ------------------------------------------------------------
  // first stage is read only by the second
  logic [4:0] pinMeta_ff;
  logic [4:0] pinSync_ff;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      pinMeta_ff <= 5'h00;
      pinSync_ff <= 5'h00;
    end else begin
      pinMeta_ff <= {dbit2OrFormSelHiIn, dbit1OrFormSelLoIn,
                     dbit0OrCodingSelIn, ifaceSelHi, ifaceSelLo};
      pinSync_ff <= pinMeta_ff;
    end
  end

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  function automatic aopm_pkg::aopm_mode_t decodeMode(input logic [1:0] s);
    aopm_pkg::aopm_mode_t m;
    m = aopm_pkg::AOPM_PAR18;
    if (s == aopm_pkg::SEL_PAR18) begin
      m = aopm_pkg::AOPM_PAR18;
    end else if (s == aopm_pkg::SEL_PAR16) begin
      m = aopm_pkg::AOPM_PAR16;
    end else if (s == aopm_pkg::SEL_BYTE) begin
      m = aopm_pkg::AOPM_BYTE;
    end else begin
      m = aopm_pkg::AOPM_SERIAL;
    end
    return m;
  endfunction

  aopm_pkg::aopm_mode_t mode_ff;
  logic [1:0] mode2_ff;
  logic coding_ff;
  logic [1:0] form_ff;
  aopm_pkg::aopm_mode_t nxt_mode;
  logic nxt_coding;
  logic [1:0] nxt_form;

  assign nxt_mode = decodeMode(pinSync_ff[1:0]);

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      mode_ff <= aopm_pkg::AOPM_PAR18;
      mode2_ff <= aopm_pkg::RST_MODE;
    end else begin
      mode_ff <= nxt_mode;
      mode2_ff <= pinSync_ff[1:0];
    end
  end

  // ------------------------------------------------------------
  // pin release tracking
  // ------------------------------------------------------------
  // the drive enable goes through the same two stages as the pins, so a
  // sample taken while this block still drove a pin is known as its own
  // output echoed back and never sets coding or form
  logic pinOe;
  logic oeMeta_ff;
  logic oeSync_ff;
  logic pinsValid;

  assign pinOe = (mode_ff == aopm_pkg::AOPM_PAR18);

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      oeMeta_ff <= 1'h1;
      oeSync_ff <= 1'h1;
    end else begin
      oeMeta_ff <= pinOe;
      oeSync_ff <= oeMeta_ff;
    end
  end
  assign pinsValid = !oeSync_ff;

  // ------------------------------------------------------------
  // coding and form selects
  // ------------------------------------------------------------
  always_comb begin
    nxt_coding = aopm_pkg::RST_CODING_STRAIGHT;
    nxt_form = aopm_pkg::RST_FORM;
    case (nxt_mode)
      aopm_pkg::AOPM_PAR18: begin
        nxt_coding = 1'b1;
      end
      aopm_pkg::AOPM_PAR16,
      aopm_pkg::AOPM_BYTE: begin
        if (pinsValid) begin
          nxt_coding = pinSync_ff[2];
          nxt_form = {pinSync_ff[4], pinSync_ff[3]};
        end else begin
          nxt_coding = coding_ff;
          nxt_form = form_ff;
        end
      end
      default: begin
        if (pinsValid) begin
          nxt_coding = pinSync_ff[2];
          nxt_form = {1'b0, pinSync_ff[3]};
        end else begin
          nxt_coding = coding_ff;
          nxt_form = form_ff;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      coding_ff <= aopm_pkg::RST_CODING_STRAIGHT;
      form_ff <= aopm_pkg::RST_FORM;
    end else begin
      coding_ff <= nxt_coding;
      form_ff <= nxt_form;
    end
  end

  // ------------------------------------------------------------
  // result coding
  // ------------------------------------------------------------
  // two's complement of an offset-binary word is its msb inverted
  logic [RESULT_W-1:0] coded_ff;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      coded_ff <= '0;
    end else if (coding_ff) begin
      coded_ff <= resultRaw;
    end else begin
      coded_ff <= {~resultRaw[RESULT_W-1], resultRaw[RESULT_W-2:0]};
    end
  end

  assign resultCoded = coded_ff;
  assign portMode = mode2_ff;
  assign serialMode = (mode_ff == aopm_pkg::AOPM_SERIAL);
  assign formSel = form_ff;

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  // the low pins carry the result lsbs; the form table that reorders
  // bytes lives in the port logic downstream, not here
  logic isPar18;
  logic isPar;

  assign isPar18 = (mode_ff == aopm_pkg::AOPM_PAR18);
  assign isPar = !serialMode;

  assign dbit0OrCodingSelOut = coded_ff[aopm_pkg::BIT_CODING];
  assign dbit0OrCodingSelOe = isPar18;
  assign dbit1OrFormSelLoOut = coded_ff[aopm_pkg::BIT_FORM_LO];
  assign dbit1OrFormSelLoOe = isPar18;
  assign dbit2OrFormSelHiOut = coded_ff[aopm_pkg::BIT_FORM_HI];
  // serial use of pin 2 is outside this block, so it is released there
  assign dbit2OrFormSelHiOe = isPar18;
  assign dbit3Out = coded_ff[aopm_pkg::BIT_DBIT3];
  assign dbit45Out = {coded_ff[aopm_pkg::BIT_DBIT5],
                      coded_ff[aopm_pkg::BIT_DBIT4]};
  assign dbit45Oe = {isPar, isPar};

endmodule

/* verif/aopm_pin_mux_asserts.sv */
// checker for the output port pin mux
`timescale 1ns/1ps
module aopm_pin_mux_chk #(
  parameter int RESULT_W = 18
) (
  // watched ports
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ifaceSelLo,
  input wire logic ifaceSelHi,
  input wire logic [RESULT_W-1:0] resultRaw,
  input wire logic [RESULT_W-1:0] resultCoded,
  input wire logic [1:0] portMode,
  input wire logic serialMode,
  input wire logic dbit0OrCodingSelIn,
  input wire logic dbit0OrCodingSelOe,
  input wire logic dbit1OrFormSelLoOe,
  input wire logic dbit3Out,
  input wire logic [1:0] dbit45Out,
  input wire logic [1:0] dbit45Oe
);
  // -------------------------------
  // properties
  // -------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // the design lets go of its own reset two edges after the pin does;
  // data checks wait out that tail
  logic [1:0] sinceRst;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sinceRst <= 2'h0;
    end else if (sinceRst != 2'h3) begin
      sinceRst <= sinceRst + 2'h1;
    end
  end
  // long holds cover the synchroniser and the internal reset tail
  chk_mode_decode: assert property (
    $stable({ifaceSelHi, ifaceSelLo})[*8]
    |-> portMode == {ifaceSelHi, ifaceSelLo}) else $error("bad mode");
  chk_serial_flag: assert property (
    serialMode == (portMode == 2'h3)) else $error("bad serial flag");
  chk_pin0_dir: assert property (
    dbit0OrCodingSelOe == (portMode == 2'h0)) else $error("bad pin0 oe");
  chk_pin1_dir: assert property (
    dbit1OrFormSelLoOe == (portMode == 2'h0)) else $error("bad pin1 oe");
  chk_pin3_data: assert property (
    sinceRst == 2'h3 |-> dbit3Out == $past(resultRaw[3]))
    else $error("bad pin3");
  chk_high_pins: assert property (
    dbit45Oe == {2{portMode != 2'h3}} && (sinceRst != 2'h3 ||
    dbit45Out == $past(resultRaw[5:4]))) else $error("bad pins 4 5");
  chk_straight_par: assert property (
    (portMode == 2'h0)[*6] |-> resultCoded == $past(resultRaw))
    else $error("bad straight coding");
  chk_twos_comp: assert property (
    (portMode == 2'h1 && !dbit0OrCodingSelIn)[*8] |-> resultCoded ==
    ($past(resultRaw) ^ {1'b1, {(RESULT_W-1){1'b0}}}))
    else $error("bad twos coding");
endmodule

bind aopm_pin_mux aopm_pin_mux_chk #(.RESULT_W(RESULT_W)) i_chk (.ref_clk,
  .reset_n, .ifaceSelLo, .ifaceSelHi, .resultRaw, .resultCoded, .portMode,
  .serialMode, .dbit0OrCodingSelIn, .dbit0OrCodingSelOe, .dbit1OrFormSelLoOe,
  .dbit3Out, .dbit45Out, .dbit45Oe);

/* verif/aopm_host_model.sv */
// host model driving the shared configuration pins
`timescale 1ns/1ps
module aopm_host_model (
  // host request and device drive
  input wire logic [1:0] reqMode,
  input wire logic [2:0] cfgPins,
  input wire logic [2:0] devOe,
  input wire logic [2:0] devOut,
  // resolved pin levels
  output logic [2:0] pinLevel
);
  logic [2:0] hostOe;
  // host lets go in full-width mode to avoid a fight on the pins
  assign hostOe = {reqMode == 2'h1 || reqMode == 2'h2,
    {2{reqMode != 2'h0}}};
  // an undriven pin shows the inverse of the device's current output value devOut
  assign pinLevel = (devOe & devOut) | (~devOe & hostOe & cfgPins)
    | (~devOe & ~hostOe & ~devOut);
endmodule

/* verif/tb_top.sv */
// self-checking bench for the output port pin mux
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [2:0] cfg = 3'h0;
  logic [17:0] raw = 18'h0;
  logic [17:0] coded, exp;
  logic [1:0] pMode, fSel, oe45, out45;
  logic serMode, d3;
  logic [2:0] oe, out, lvl;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  always #2 ref_clk = ~ref_clk;
  aopm_pin_mux i_dut (.ref_clk, .reset_n, .ifaceSelLo(mode[0]),
    .ifaceSelHi(mode[1]), .resultRaw(raw), .resultCoded(coded),
    .portMode(pMode), .serialMode(serMode), .formSel(fSel),
    .dbit0OrCodingSelIn(lvl[0]), .dbit0OrCodingSelOut(out[0]),
    .dbit0OrCodingSelOe(oe[0]), .dbit1OrFormSelLoIn(lvl[1]),
    .dbit1OrFormSelLoOut(out[1]), .dbit1OrFormSelLoOe(oe[1]),
    .dbit2OrFormSelHiIn(lvl[2]), .dbit2OrFormSelHiOut(out[2]),
    .dbit2OrFormSelHiOe(oe[2]), .dbit3Out(d3), .dbit45Out(out45),
    .dbit45Oe(oe45));
  aopm_host_model i_host (.reqMode(mode), .cfgPins(cfg), .devOe(oe),
    .devOut(out), .pinLevel(lvl));
  // -------------------------------
  // tasks
  // -------------------------------
  task automatic cmp(input logic [17:0] got, input logic [17:0] want);
    checked++;
    if (got !== want) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic print_verdict;
    $display("checked=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic apply(input logic [1:0] m, input logic [2:0] c,
                       input logic [17:0] r);
    @(posedge ref_clk);
    #1;
    mode = m;
    cfg = c;
    raw = r;
    repeat (12) @(posedge ref_clk);
    #1;
  endtask
  // -------------------------------
  // sequence
  // -------------------------------
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 500) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 2; c++) begin
        apply(m[1:0], {c[0], ~c[0], c[0]}, 18'h2a5c3 ^ {18{c[0]}});
        exp = (m == 0 || c == 1) ? raw : raw ^ 18'h20000;
        cmp(coded, exp);
        cmp(pMode, m[1:0]);
        cmp(serMode, m == 3);
        cmp(oe, (m == 0) ? 3'h7 : 3'h0);
        cmp(fSel, (m == 0) ? 2'h0 : (m == 3) ? {1'b0, cfg[1]} : cfg[2:1]);
        cmp({out45, d3, out}, exp[5:0]);
        cmp(oe45, (m == 3) ? 2'h0 : 2'h3);
      end
    end
    print_verdict();
  end
endmodule
